// File: tb/ddr_sdram_pin_interface_test.sv
/*
  Self-checking bench: controller and device joined by the bundle.
  Assumes the controller makes the link clock from clk.
*/
module ddr_sdram_pin_interface_test
  import ddrpi_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic mem_reset = 1'b1;
  logic req_valid = 1'b0;
  logic req_ready;
  ddrpi_cmd_t req_cmd = DDRPI_NOP;
  logic [1:0] req_bank = 2'h0;
  logic [12:0] req_addr = 13'h0000;
  logic [31:0] req_wdata = 32'h0;
  logic [3:0] req_wmask = 4'h0;
  logic rsp_valid;
  logic [31:0] rsp_rdata;
  logic [3:0] bank_open;
  logic [12:0] mode_base;
  logic [12:0] mode_ext;
  logic [31:0] rng = 32'h1CFE;
  logic [15:0] mem_m [128];
  logic [1:0] row_m [4];
  logic [3:0] open_m = 4'h0;
  logic [12:0] base_m = 13'h0000;
  logic [12:0] ext_m = 13'h0000;
  logic [31:0] exp_q [$];
  int mismatches = 0;
  int check_count = 0;

  ddrpi_if ddrpi_if_i ();
  ddrpi_ctrl ddrpi_ctrl_i (.clk(clk), .reset(reset), .link(ddrpi_if_i),
    .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd),
    .req_bank(req_bank), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_wmask(req_wmask), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  ddrpi_mem ddrpi_mem_i (.reset(mem_reset), .link(ddrpi_if_i),
    .bank_open(bank_open), .mode_base(mode_base), .mode_ext(mode_ext));
  ddrpi_chk ddrpi_chk_i (.clk(clk), .reset(reset), .mem_reset(mem_reset),
    .ck(ddrpi_if_i.ck), .cs_n(ddrpi_if_i.cs_n), .ras_n(ddrpi_if_i.ras_n),
    .cas_n(ddrpi_if_i.cas_n), .we_n(ddrpi_if_i.we_n),
    .write_byte_mask(ddrpi_if_i.write_byte_mask),
    .ctrl_data_o(ddrpi_if_i.ctrl_data_o),
    .ctrl_data_oe_n(ddrpi_if_i.ctrl_data_oe_n),
    .ctrl_strobe_oe_n(ddrpi_if_i.ctrl_strobe_oe_n),
    .dev_data_oe_n(ddrpi_if_i.dev_data_oe_n),
    .dev_strobe_oe_n(ddrpi_if_i.dev_strobe_oe_n),
    .byte_strobe(ddrpi_if_i.byte_strobe));

  initial
  begin
    forever #2 clk = ~clk;
  end

  function logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xs

  function logic [6:0] idx(input logic [1:0] b, input logic [12:0] a,
                           input logic k);
    return {b, row_m[b], a[2:1], k};
  endfunction : idx

  task chk(input string name, input logic [31:0] exp,
           input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task test_done();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  // Each read result against the oldest expectation
  always @(posedge clk)
  begin
    if (rsp_valid === 1'b1)
      chk("rsp_rdata", exp_q.size() > 0 ? exp_q.pop_front() : ~rsp_rdata,
          rsp_rdata);
  end

  // One request; notes the expected outcome, checks device state
  task send(input ddrpi_cmd_t c, input logic [1:0] b,
            input logic [12:0] a, input logic [31:0] wd,
            input logic [3:0] wm);
    int n;
    n = 0;
    req_cmd = c;
    req_bank = b;
    req_addr = a;
    req_wdata = wd;
    req_wmask = wm;
    req_valid = 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (req_ready !== 1'b1 && n < 64);
    #1;
    req_valid = 1'b0;
    if (n >= 64)
    begin
      mismatches++;
      $display("Error req_ready expected 1 seen 0");
      test_done();
    end
    case (c)
      DDRPI_ACT:
      begin
        row_m[b] = a[1:0];
        open_m[b] = 1'b1;
      end
      DDRPI_WR:
        for (int i = 0; i < 4; i++)
          if (!wm[i])
            mem_m[idx(b, a, i[1])][8 * i[0] +: 8] = wd[8 * i +: 8];
      DDRPI_RD:
        exp_q.push_back({mem_m[idx(b, a, 1'b1)], mem_m[idx(b, a, 1'b0)]});
      DDRPI_PRE:
        open_m = a[10] ? 4'h0 : open_m & ~(4'h1 << b);
      DDRPI_MODE:
        if (b == 2'h0)
          base_m = a;
        else if (b == 2'h1)
          ext_m = a;
      default:
        n = 0;
    endcase
    if ((c == DDRPI_RD || c == DDRPI_WR) && a[10])
      open_m[b] = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk("bank_open", {28'h0, open_m}, {28'h0, bank_open});
    chk("mode_base", {19'h0, base_m}, {19'h0, mode_base});
    chk("mode_ext", {19'h0, ext_m}, {19'h0, mode_ext});
  endtask : send

  initial
  begin
    logic [31:0] r;
    logic [12:0] a;
    repeat (5) @(posedge clk);
    #1;
    reset = 1'b0;
    repeat (24) @(posedge clk);
    #1;
    mem_reset = 1'b0;
    repeat (12) @(posedge clk);
    #1;
    for (int s = 0; s < 4; s++)
    begin
      r = xs();
      send(DDRPI_MODE, s[1:0], r[12:0], 32'h0, 4'h0);
    end
    $display("test mode loads done");
    for (int b = 0; b < 4; b++)
    begin
      r = xs();
      send(DDRPI_ACT, b[1:0], r[12:0], 32'h0, 4'h0);
    end
    $display("test activates done");
    // Full write, masked overwrite, read back per bank
    for (int i = 0; i < 8; i++)
    begin
      r = xs();
      a = {10'h000, r[2:1], 1'b0};
      send(DDRPI_WR, i[1:0], a, xs(), 4'h0);
      send(DDRPI_WR, i[1:0], a, xs(), r[7:4]);
      send(DDRPI_RD, i[1:0], a, 32'h0, 4'h0);
    end
    $display("test masked writes done");
    send(DDRPI_DESEL, 2'h0, 13'h0400, 32'h0, 4'h0);
    send(DDRPI_NOP, 2'h1, 13'h0400, 32'h0, 4'h0);
    send(DDRPI_BST, 2'h2, 13'h0400, 32'h0, 4'h0);
    $display("test idle codes done");
    send(DDRPI_PRE, 2'h2, 13'h0000, 32'h0, 4'h0);
    send(DDRPI_RD, 2'h3, a | 13'h0400, 32'h0, 4'h0);
    send(DDRPI_WR, 2'h1, a | 13'h0400, xs(), 4'h0);
    send(DDRPI_RD, 2'h1, a, 32'h0, 4'h0);
    send(DDRPI_PRE, 2'h0, 13'h0400, 32'h0, 4'h0);
    send(DDRPI_REF, 2'h0, 13'h0000, 32'h0, 4'h0);
    for (int n = 0; n < 32 && exp_q.size() > 0; n++)
      @(posedge clk);
    chk("reads_left", 32'h0, exp_q.size());
    $display("test precharge done");
    test_done();
  end
endmodule : ddr_sdram_pin_interface_test

// File: tb/ddrpi_chk.sv
/*
  Checker of the pin bundle between controller and device.
  Assumes instantiation beside the bundle, with both resets.
*/
module ddrpi_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic mem_reset,
  input wire logic ck,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] write_byte_mask,
  input wire logic [15:0] ctrl_data_o,
  input wire logic ctrl_data_oe_n,
  input wire logic [1:0] ctrl_strobe_oe_n,
  input wire logic dev_data_oe_n,
  input wire logic [1:0] dev_strobe_oe_n,
  input wire logic [1:0] byte_strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic rd;
  logic wr;
  assign rd = !cs_n && ras_n && !cas_n && we_n;
  assign wr = !cs_n && ras_n && !cas_n && !we_n;

  read_drive_a: assert property (
    @(posedge ck) disable iff (mem_reset)
    rd |=> !dev_data_oe_n ##1 dev_data_oe_n)
    else $error("device read drive window wrong");
  idle_release_a: assert property (
    @(posedge ck) disable iff (mem_reset)
    !rd |=> dev_data_oe_n && (&dev_strobe_oe_n))
    else $error("device drives outside a read");
  desel_quiet_a: assert property (
    @(posedge ck) disable iff (mem_reset)
    cs_n |=> dev_data_oe_n)
    else $error("device answered a deselect");
  write_drive_a: assert property (
    @(posedge ck) disable iff (mem_reset)
    wr |=> !ctrl_data_oe_n ##1 ctrl_data_oe_n)
    else $error("write data window wrong");
  no_contention_a: assert property (
    @(posedge clk) disable iff (reset)
    (ctrl_data_oe_n || dev_data_oe_n) &&
    (&(ctrl_strobe_oe_n | dev_strobe_oe_n)))
    else $error("both ends drive the bus");
  read_strobe_a: assert property (
    @(posedge clk) disable iff (reset || mem_reset)
    !dev_data_oe_n |-> byte_strobe == {2{ck}})
    else $error("read strobe not aligned to link clock");
  write_centre_a: assert property (
    @(posedge clk) disable iff (reset)
    !ctrl_strobe_oe_n[0] && $changed(byte_strobe) |-> $stable(ctrl_data_o))
    else $error("write data moves on a strobe edge");
  mask_stable_a: assert property (
    @(posedge clk) disable iff (reset)
    !ctrl_strobe_oe_n[1] && $changed(byte_strobe)
    |-> $stable(write_byte_mask))
    else $error("write mask moves on a strobe edge");
  data_stagger_a: assert property (
    @(posedge clk) disable iff (reset)
    !ctrl_data_oe_n && $changed(ctrl_data_o) |-> $stable(byte_strobe))
    else $error("strobe moves with write data");
endmodule : ddrpi_chk

// File: verilog/ddrpi_ctrl.sv
/*
  Controller end of the DDR pin interface. Divides the system clock
  by four into the link clock, launches one command per request and
  runs two-beat write and read bursts.
  Assumes the device keeps to the read timing of the device end.
*/
`include "ddrpi_map.svh"

module ddrpi_ctrl
  import ddrpi_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  ddrpi_if.ctrl link,
  input wire logic req_valid,
  output logic req_ready,
  input wire ddrpi_cmd_t req_cmd,
  input wire logic [`DDRPI_BANK_W-1:0] req_bank,
  input wire logic [`DDRPI_ADDR_W-1:0] req_addr,
  input wire logic [2*`DDRPI_DATA_W-1:0] req_wdata,
  input wire logic [2*`DDRPI_LANES-1:0] req_wmask,
  output logic rsp_valid,
  output logic [2*`DDRPI_DATA_W-1:0] rsp_rdata
);

  localparam logic [3:0] PINS_DESEL = {1'b1, `DDRPI_CODE_NOP};
  localparam int DW = `DDRPI_DATA_W;
  localparam int LW = `DDRPI_LANE_W;
  localparam int NL = `DDRPI_LANES;

  function automatic logic [3:0] pins_of(input ddrpi_cmd_t c);
    logic [3:0] p;
    p = PINS_DESEL;
    unique case (c)
      // Live code under a high select, which the device must mask
      DDRPI_DESEL: p = {1'b1, `DDRPI_CODE_PRE};
      DDRPI_NOP: p = {1'b0, `DDRPI_CODE_NOP};
      DDRPI_ACT: p = {1'b0, `DDRPI_CODE_ACT};
      DDRPI_RD: p = {1'b0, `DDRPI_CODE_RD};
      DDRPI_WR: p = {1'b0, `DDRPI_CODE_WR};
      DDRPI_PRE: p = {1'b0, `DDRPI_CODE_PRE};
      DDRPI_REF: p = {1'b0, `DDRPI_CODE_REF};
      DDRPI_BST: p = {1'b0, `DDRPI_CODE_BST};
      DDRPI_MODE: p = {1'b0, `DDRPI_CODE_MODE};
    endcase
    return p;
  endfunction : pins_of

  ddrpi_ctrl_state_t st_r, st_nxt;
  logic [`DDRPI_PH_W-1:0] ph_r, ph_nxt;
  logic ck_r, ck_nxt;
  logic [3:0] pins_r, pins_nxt;
  logic [`DDRPI_BANK_W-1:0] bank_r, bank_nxt;
  logic [`DDRPI_ADDR_W-1:0] addr_r, addr_nxt;
  ddrpi_cmd_t cmd_r, cmd_nxt;
  logic [2*DW-1:0] wdata_r, wdata_nxt;
  logic [2*NL-1:0] wmask_r, wmask_nxt;
  logic [NL-1:0] mask_r, mask_nxt;
  logic [DW-1:0] dout_r, dout_nxt;
  logic doe_n_r, doe_n_nxt;
  logic [NL-1:0] stb_r, stb_nxt;
  logic [NL-1:0] soe_n_r, soe_n_nxt;
  logic [2*DW-1:0] rdata_r, rdata_nxt;
  logic rsp_r, rsp_nxt;
  logic [NL-1:0] fell_r, fell_nxt;
  logic [NL-1:0] stb_s1_r, stb_s2_r, stb_s3_r;
  logic [DW-1:0] din_s1_r, din_s2_r;
  logic [NL-1:0] rise, fall;

  // Read strobe and data cross in through two flops
  always_ff @(posedge clk)
  begin
    stb_s1_r <= link.byte_strobe;
    stb_s2_r <= stb_s1_r;
    stb_s3_r <= stb_s2_r;
    din_s1_r <= link.data;
    din_s2_r <= din_s1_r;
  end

  assign rise = stb_s2_r & ~stb_s3_r;
  assign fall = ~stb_s2_r & stb_s3_r;
  assign req_ready = (st_r == C_IDLE) && (ph_r == `DDRPI_PH_LAUNCH);

  always_comb
  begin
    ph_nxt = ph_r + 1'b1;
    ck_nxt = ~ph_nxt[`DDRPI_CK_PH_BIT];
    st_nxt = st_r;
    pins_nxt = pins_r;
    bank_nxt = bank_r;
    addr_nxt = addr_r;
    cmd_nxt = cmd_r;
    wdata_nxt = wdata_r;
    wmask_nxt = wmask_r;
    mask_nxt = mask_r;
    dout_nxt = dout_r;
    doe_n_nxt = doe_n_r;
    stb_nxt = stb_r;
    soe_n_nxt = soe_n_r;
    rdata_nxt = rdata_r;
    rsp_nxt = 1'b0;
    fell_nxt = fell_r;
    unique case (st_r)
      C_IDLE:
        if (req_valid && req_ready)
        begin
          // Command stands over the next rising link clock
          pins_nxt = pins_of(req_cmd);
          bank_nxt = req_bank;
          addr_nxt = req_addr;
          cmd_nxt = req_cmd;
          wdata_nxt = req_wdata;
          wmask_nxt = req_wmask;
          st_nxt = C_CMD;
        end
      C_CMD:
        if (ph_r == `DDRPI_PH_LAUNCH)
        begin
          pins_nxt = PINS_DESEL;
          if (cmd_r == DDRPI_WR)
          begin
            dout_nxt = wdata_r[DW-1:0];
            mask_nxt = wmask_r[NL-1:0];
            doe_n_nxt = 1'b0;
            soe_n_nxt = '0;
            stb_nxt = '0;
            st_nxt = C_WR;
          end
          else if (cmd_r == DDRPI_RD)
          begin
            fell_nxt = '0;
            st_nxt = C_RD;
          end
          else
            st_nxt = C_IDLE;
        end
      C_WR:
      begin
        // Strobe edges fall mid-beat
        unique case (ph_r)
          `DDRPI_PH_STB_RISE: stb_nxt = '1;
          `DDRPI_PH_BEAT1:
          begin
            dout_nxt = wdata_r[2*DW-1:DW];
            mask_nxt = wmask_r[2*NL-1:NL];
          end
          `DDRPI_PH_STB_FALL: stb_nxt = '0;
          `DDRPI_PH_LAUNCH:
          begin
            doe_n_nxt = 1'b1;
            soe_n_nxt = '1;
            mask_nxt = '0;
            st_nxt = C_IDLE;
          end
        endcase
      end
      C_RD:
      begin
        for (int i = 0; i < NL; i++)
        begin
          if (rise[i])
            rdata_nxt[i*LW +: LW] = din_s2_r[i*LW +: LW];
          if (fall[i])
            rdata_nxt[DW + i*LW +: LW] = din_s2_r[i*LW +: LW];
        end
        fell_nxt = fell_r | fall;
        if (&(fell_r | fall))
        begin
          rsp_nxt = 1'b1;
          st_nxt = C_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st_r <= C_IDLE;
      ph_r <= `DDRPI_PH_RST;
      ck_r <= 1'b0;
      pins_r <= PINS_DESEL;
      bank_r <= '0;
      addr_r <= '0;
      cmd_r <= DDRPI_NOP;
      wdata_r <= '0;
      wmask_r <= '0;
      mask_r <= '0;
      dout_r <= '0;
      doe_n_r <= 1'b1;
      stb_r <= '0;
      soe_n_r <= '1;
      rdata_r <= '0;
      rsp_r <= 1'b0;
      fell_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      ph_r <= ph_nxt;
      ck_r <= ck_nxt;
      pins_r <= pins_nxt;
      bank_r <= bank_nxt;
      addr_r <= addr_nxt;
      cmd_r <= cmd_nxt;
      wdata_r <= wdata_nxt;
      wmask_r <= wmask_nxt;
      mask_r <= mask_nxt;
      dout_r <= dout_nxt;
      doe_n_r <= doe_n_nxt;
      stb_r <= stb_nxt;
      soe_n_r <= soe_n_nxt;
      rdata_r <= rdata_nxt;
      rsp_r <= rsp_nxt;
      fell_r <= fell_nxt;
    end
  end

  assign link.ck = ck_r;
  assign {link.cs_n, link.ras_n, link.cas_n, link.we_n} = pins_r;
  assign link.bank_sel = bank_r;
  assign link.addr = addr_r;
  assign link.write_byte_mask = mask_r;
  assign link.ctrl_data_o = dout_r;
  assign link.ctrl_data_oe_n = doe_n_r;
  assign link.ctrl_strobe_o = stb_r;
  assign link.ctrl_strobe_oe_n = soe_n_r;
  assign rsp_valid = rsp_r;
  assign rsp_rdata = rdata_r;

endmodule : ddrpi_ctrl

// File: verilog/ddrpi_if.sv
/*
  Pin bundle between controller and memory device.
  Assumes each end drives only its own output and enable signals;
  the shared data and strobe levels are resolved here.
*/
`include "ddrpi_map.svh"

interface ddrpi_if;
  logic ck;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [`DDRPI_BANK_W-1:0] bank_sel;
  logic [`DDRPI_ADDR_W-1:0] addr;
  logic [`DDRPI_LANES-1:0] write_byte_mask;
  logic [`DDRPI_DATA_W-1:0] ctrl_data_o;
  logic ctrl_data_oe_n;
  logic [`DDRPI_DATA_W-1:0] dev_data_o;
  logic dev_data_oe_n;
  logic [`DDRPI_DATA_W-1:0] data;
  logic [`DDRPI_LANES-1:0] ctrl_strobe_o;
  logic [`DDRPI_LANES-1:0] ctrl_strobe_oe_n;
  logic [`DDRPI_LANES-1:0] dev_strobe_o;
  logic [`DDRPI_LANES-1:0] dev_strobe_oe_n;
  logic [`DDRPI_LANES-1:0] byte_strobe;

  // Undriven wire reads low
  assign data = !ctrl_data_oe_n ? ctrl_data_o :
                !dev_data_oe_n ? dev_data_o : '0;
  assign byte_strobe = (ctrl_strobe_o & ~ctrl_strobe_oe_n) |
                       (dev_strobe_o & ~dev_strobe_oe_n);

  modport ctrl (
    output ck, cs_n, ras_n, cas_n, we_n, bank_sel, addr, write_byte_mask,
    output ctrl_data_o, ctrl_data_oe_n, ctrl_strobe_o, ctrl_strobe_oe_n,
    input data, byte_strobe
  );

  modport dev (
    input ck, cs_n, ras_n, cas_n, we_n, bank_sel, addr, write_byte_mask,
    input data, byte_strobe,
    output dev_data_o, dev_data_oe_n, dev_strobe_o, dev_strobe_oe_n
  );
endinterface : ddrpi_if

// File: verilog/ddrpi_lane.sv
/*
  One byte lane of write capture on both edges of its data strobe.
  Assumes the strobe edges sit in the middle of each data beat.
*/
`include "ddrpi_map.svh"

module ddrpi_lane (
  input wire logic strobe,
  input wire logic [`DDRPI_LANE_W-1:0] data,
  input wire logic mask,
  output logic [`DDRPI_LANE_W-1:0] beat0_data,
  output logic beat0_mask,
  output logic [`DDRPI_LANE_W-1:0] beat1_data,
  output logic beat1_mask
);

  // First beat on the rising strobe edge
  always_ff @(posedge strobe)
  begin
    beat0_data <= data;
    beat0_mask <= mask;
  end

  // Second beat on the falling strobe edge
  always_ff @(negedge strobe)
  begin
    beat1_data <= data;
    beat1_mask <= mask;
  end

endmodule : ddrpi_lane

// File: verilog/ddrpi_map.svh
/*
  Constants of the DDR pin interface: widths, command codes, phases.
  Assumes inclusion by every design file of the block.
*/
`ifndef DDRPI_MAP_SVH
`define DDRPI_MAP_SVH

`define DDRPI_ADDR_W 13
`define DDRPI_DATA_W 16
`define DDRPI_LANE_W 8
`define DDRPI_LANES 2
`define DDRPI_BANK_W 2
`define DDRPI_BANKS 4
// Bank depth in Mbit per organisation
`define DDRPI_BANK_MBIT_X4 16
`define DDRPI_BANK_MBIT_X8 8
`define DDRPI_BANK_MBIT_X16 4
`define DDRPI_AP_BIT 10
// Modelled array: row and column bits kept
`define DDRPI_ROW_SEL_W 2
`define DDRPI_COL_SEL_W 3
`define DDRPI_COL_LO 1
`define DDRPI_IDX_W 7
`define DDRPI_WORDS 128
// Command codes on {row strobe, column strobe, write enable}, all low true
`define DDRPI_CODE_MODE 3'h0
`define DDRPI_CODE_REF 3'h1
`define DDRPI_CODE_PRE 3'h2
`define DDRPI_CODE_ACT 3'h3
`define DDRPI_CODE_WR 3'h4
`define DDRPI_CODE_RD 3'h5
`define DDRPI_CODE_BST 3'h6
`define DDRPI_CODE_NOP 3'h7
// Bank select values during a mode load
`define DDRPI_SEL_BASE 2'h0
`define DDRPI_SEL_EXT 2'h1
`define DDRPI_MODE_RST 13'h0000
// Controller phases of the link clock, four system clocks per period
`define DDRPI_PH_W 2
`define DDRPI_PH_RST 2'h2
`define DDRPI_PH_LAUNCH 2'h1
`define DDRPI_PH_STB_RISE 2'h2
`define DDRPI_PH_BEAT1 2'h3
`define DDRPI_PH_STB_FALL 2'h0
`define DDRPI_CK_PH_BIT 1

`endif

// File: verilog/ddrpi_mem.sv
/*
  Memory device end of the DDR pin interface: command decode, bank
  state, mode registers, a small modelled array, read drive and
  masked write capture per byte lane.
  Assumes the link clock from the controller; reset may come from any
  clock, it passes two link clock flops. Bursts are two beats long, reads start in the link
  cycle of the command, writes commit two link rises after it.
*/
`include "ddrpi_map.svh"

module ddrpi_mem
  import ddrpi_pkg::*;
(
  input wire logic reset,
  ddrpi_if.dev link,
  output logic [`DDRPI_BANKS-1:0] bank_open,
  output logic [`DDRPI_ADDR_W-1:0] mode_base,
  output logic [`DDRPI_ADDR_W-1:0] mode_ext
);

  localparam int PAIR_W = `DDRPI_IDX_W - 1;

  ddrpi_cmd_t cmd;
  logic [`DDRPI_BANK_W-1:0] bank;
  logic [PAIR_W-1:0] cmd_pair;

  logic [`DDRPI_BANKS-1:0] open_r;
  logic [`DDRPI_BANKS-1:0] open_nxt;
  logic [`DDRPI_ROW_SEL_W-1:0] row_r [`DDRPI_BANKS];
  logic [`DDRPI_ROW_SEL_W-1:0] row_nxt [`DDRPI_BANKS];
  logic [`DDRPI_ADDR_W-1:0] mode_base_r;
  logic [`DDRPI_ADDR_W-1:0] mode_base_nxt;
  logic [`DDRPI_ADDR_W-1:0] mode_ext_r;
  logic [`DDRPI_ADDR_W-1:0] mode_ext_nxt;
  logic rd_act_r;
  logic rd_act_nxt;
  logic [`DDRPI_DATA_W-1:0] rd_b0_r;
  logic [`DDRPI_DATA_W-1:0] rd_b0_nxt;
  logic [`DDRPI_DATA_W-1:0] rd_b1_r;
  logic [`DDRPI_DATA_W-1:0] rd_b1_nxt;
  logic [1:0] wr_stage_r;
  logic [1:0] wr_stage_nxt;
  logic [PAIR_W-1:0] wr_pair_r;
  logic [PAIR_W-1:0] wr_pair_nxt;
  logic [`DDRPI_DATA_W-1:0] mem_r [`DDRPI_WORDS];
  logic [`DDRPI_DATA_W-1:0] mem_nxt [`DDRPI_WORDS];

  logic [`DDRPI_LANE_W-1:0] b0_data [`DDRPI_LANES];
  logic [`DDRPI_LANE_W-1:0] b1_data [`DDRPI_LANES];
  logic [`DDRPI_LANES-1:0] b0_mask;
  logic [`DDRPI_LANES-1:0] b1_mask;
  logic rst_s1_r;
  logic rst_s2_r;

  // Reset arrives from the system clock side
  always_ff @(posedge link.ck)
  begin
    rst_s1_r <= reset;
    rst_s2_r <= rst_s1_r;
  end

  // Command decode from select and the three strobes
  always_comb
  begin
    if (link.cs_n)
      cmd = DDRPI_DESEL;
    else
    begin
      unique case ({link.ras_n, link.cas_n, link.we_n})
        `DDRPI_CODE_MODE: cmd = DDRPI_MODE;
        `DDRPI_CODE_REF: cmd = DDRPI_REF;
        `DDRPI_CODE_PRE: cmd = DDRPI_PRE;
        `DDRPI_CODE_ACT: cmd = DDRPI_ACT;
        `DDRPI_CODE_WR: cmd = DDRPI_WR;
        `DDRPI_CODE_RD: cmd = DDRPI_RD;
        `DDRPI_CODE_BST: cmd = DDRPI_BST;
        `DDRPI_CODE_NOP: cmd = DDRPI_NOP;
      endcase
    end
  end

  assign bank = link.bank_sel;
  // Location: bank, its open row, column pair
  assign cmd_pair = {bank, row_r[bank],
                     link.addr[`DDRPI_COL_SEL_W-1:`DDRPI_COL_LO]};

  // Per-lane write capture
  for (genvar i = 0; i < `DDRPI_LANES; i++)
  begin : g_lane
    ddrpi_lane u_lane (
      .strobe(link.byte_strobe[i]),
      .data(link.data[i*`DDRPI_LANE_W +: `DDRPI_LANE_W]),
      .mask(link.write_byte_mask[i]),
      .beat0_data(b0_data[i]),
      .beat0_mask(b0_mask[i]),
      .beat1_data(b1_data[i]),
      .beat1_mask(b1_mask[i])
    );
  end

  // Bank, mode and burst control
  always_comb
  begin
    open_nxt = open_r;
    row_nxt = row_r;
    mode_base_nxt = mode_base_r;
    mode_ext_nxt = mode_ext_r;
    rd_act_nxt = 1'b0;
    rd_b0_nxt = rd_b0_r;
    rd_b1_nxt = rd_b1_r;
    wr_stage_nxt = {wr_stage_r[0], 1'b0};
    wr_pair_nxt = wr_pair_r;
    unique case (cmd)
      DDRPI_ACT:
      begin
        open_nxt[bank] = 1'b1;
        row_nxt[bank] = link.addr[`DDRPI_ROW_SEL_W-1:0];
      end
      DDRPI_RD:
      begin
        rd_act_nxt = 1'b1;
        rd_b0_nxt = mem_r[{cmd_pair, 1'b0}];
        rd_b1_nxt = mem_r[{cmd_pair, 1'b1}];
        if (link.addr[`DDRPI_AP_BIT])
          open_nxt[bank] = 1'b0;
      end
      DDRPI_WR:
      begin
        wr_stage_nxt[0] = 1'b1;
        wr_pair_nxt = cmd_pair;
        if (link.addr[`DDRPI_AP_BIT])
          open_nxt[bank] = 1'b0;
      end
      DDRPI_PRE:
      begin
        if (link.addr[`DDRPI_AP_BIT])
          open_nxt = '0;
        else
          open_nxt[bank] = 1'b0;
      end
      DDRPI_MODE:
      begin
        if (bank == `DDRPI_SEL_BASE)
          mode_base_nxt = link.addr;
        else if (bank == `DDRPI_SEL_EXT)
          mode_ext_nxt = link.addr;
      end
      DDRPI_DESEL, DDRPI_NOP, DDRPI_REF, DDRPI_BST:
      begin
      end
    endcase
  end

  // Commands taken on the rising link clock
  always_ff @(posedge link.ck)
  begin
    if (rst_s2_r)
    begin
      open_r <= '0;
      row_r <= '{default: '0};
      mode_base_r <= `DDRPI_MODE_RST;
      mode_ext_r <= `DDRPI_MODE_RST;
      rd_act_r <= 1'b0;
      rd_b0_r <= '0;
      rd_b1_r <= '0;
      wr_stage_r <= '0;
      wr_pair_r <= '0;
    end
    else
    begin
      open_r <= open_nxt;
      row_r <= row_nxt;
      mode_base_r <= mode_base_nxt;
      mode_ext_r <= mode_ext_nxt;
      rd_act_r <= rd_act_nxt;
      rd_b0_r <= rd_b0_nxt;
      rd_b1_r <= rd_b1_nxt;
      wr_stage_r <= wr_stage_nxt;
      wr_pair_r <= wr_pair_nxt;
    end
  end

  // Array write, unmasked bytes only
  always_comb
  begin
    mem_nxt = mem_r;
    if (wr_stage_r[1])
    begin
      for (int i = 0; i < `DDRPI_LANES; i++)
      begin
        if (!b0_mask[i])
          mem_nxt[{wr_pair_r, 1'b0}][i*`DDRPI_LANE_W +: `DDRPI_LANE_W] =
            b0_data[i];
        if (!b1_mask[i])
          mem_nxt[{wr_pair_r, 1'b1}][i*`DDRPI_LANE_W +: `DDRPI_LANE_W] =
            b1_data[i];
      end
    end
  end

  always_ff @(posedge link.ck)
  begin
    mem_r <= mem_nxt;
  end

  // Read burst: first beat while clock high, second while low
  assign link.dev_data_o = link.ck ? rd_b0_r : rd_b1_r;
  assign link.dev_data_oe_n = ~rd_act_r;
  assign link.dev_strobe_o = {`DDRPI_LANES{link.ck & rd_act_r}};
  assign link.dev_strobe_oe_n = {`DDRPI_LANES{~rd_act_r}};

  assign bank_open = open_r;
  assign mode_base = mode_base_r;
  assign mode_ext = mode_ext_r;

endmodule : ddrpi_mem

// File: verilog/ddrpi_pkg.sv
/*
  Types of the DDR pin interface: commands and controller states.
  Assumes nothing beyond the constants header.
*/
package ddrpi_pkg;

  typedef enum logic [3:0] {
    DDRPI_DESEL, DDRPI_NOP, DDRPI_ACT, DDRPI_RD, DDRPI_WR,
    DDRPI_PRE, DDRPI_REF, DDRPI_BST, DDRPI_MODE
  } ddrpi_cmd_t;

  typedef enum logic [1:0] {
    C_IDLE, C_CMD, C_WR, C_RD
  } ddrpi_ctrl_state_t;

endpackage : ddrpi_pkg
